/* logic/rule_table_indirect_access.sv */
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module rule_table_indirect_access
  import rule_table_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire apb_req_type apb_req,
  output apb_rsp_type apb_rsp
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    apb_rsp_type rsp;
    logic [7:0] sel;
    logic [7:0] off;
    logic [PORTS-1:0][ENTRY_BYTES-1:0][7:0] hold;
    logic [PORTS-1:0][ENTRY_BYTES-1:0][7:0] fetch;
    logic [PORTS-1:0][ENTRY_BYTES-1:0] be;
    logic [PORTS-1:0][4:0] ctl;
    logic rd_done;
    logic wr_done;
    logic [2:0] op_port;
    logic [3:0] op_idx;
    eng_type eng;
  } state_type;

  state_type st_reg;
  state_type st_next;
  logic [8*ENTRY_BYTES-1:0] table_mem [0:PORTS*ENTRIES-1];
  logic [8*ENTRY_BYTES-1:0] mem_rd;
  logic [8*ENTRY_BYTES-1:0] mem_wd;
  logic mem_we;
  logic [6:0] mem_addr;
  logic port_ok;
  logic wr_sel;
  logic rd_sel;
  logic [2:0] pidx;
  logic [3:0] off_lo;
  logic acc;
  logic data_hit;
  logic [7:0] ind_byte;

  // ****************************************
  // decode
  // ****************************************
  assign port_ok = st_reg.sel[7:5] == TABLE_RULE &&
                   st_reg.sel[3:0] >= PORT_FIRST &&
                   st_reg.sel[3:0] <= PORT_LAST;
  assign wr_sel = port_ok && !st_reg.sel[SEL_DIR_BIT];
  assign rd_sel = port_ok && st_reg.sel[SEL_DIR_BIT];
  assign pidx = st_reg.sel[2:0] - 3'd1;
  assign off_lo = st_reg.off[3:0];
  assign acc = apb_req.psel && apb_req.penable && st_reg.rsp.pready;
  assign data_hit = apb_req.paddr == DATA_ADDR;
  assign mem_addr = {st_reg.op_port, st_reg.op_idx};
  assign apb_rsp = st_reg.rsp;

  // ****************************************
  // indirect byte read view
  // ****************************************
  always_comb
  begin
    ind_byte = 8'h00;
    if (st_reg.off <= LAST_BYTE)
    begin
      ind_byte = st_reg.fetch[pidx][off_lo];
    end
    else
    begin
      case (st_reg.off)
        BE_UPPER_OFF: ind_byte = {2'b00, st_reg.be[pidx][13:8]};
        BE_LOWER_OFF: ind_byte = st_reg.be[pidx][7:0];
        CTL_OFF: ind_byte = {1'b0, st_reg.wr_done, st_reg.rd_done,
                             st_reg.ctl[pidx]};
        default: ind_byte = 8'h00;
      endcase
    end
  end

  // ****************************************
  // table memory
  // ****************************************
  always_comb
  begin
    mem_rd = table_mem[mem_addr];
    mem_wd = mem_rd;
    for (int k = 0; k < ENTRY_BYTES; k++)
    begin
      // enable bit 13 guards byte 0, bit 0 guards byte 13
      if (st_reg.be[st_reg.op_port][ENTRY_BYTES-1-k])
      begin
        mem_wd[8*k +: 8] = st_reg.hold[st_reg.op_port][k];
      end
    end
    mem_we = st_reg.eng == S_WRITE;
  end

  // bytes are stored as written; format field is not interpreted
  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      table_mem[mem_addr] <= mem_wd;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    // one wait state: answer registered in first access cycle
    st_next.rsp.pready = apb_req.psel && apb_req.penable &&
                         !st_reg.rsp.pready;
    st_next.rsp.pslverr = 1'b0;
    st_next.rsp.prdata = 32'h0000_0000;
    if (st_next.rsp.pready)
    begin
      case (apb_req.paddr)
        SEL_ADDR: st_next.rsp.prdata = {24'h00_0000, st_reg.sel};
        OFF_ADDR: st_next.rsp.prdata = {24'h00_0000, st_reg.off};
        DATA_ADDR:
        begin
          if (rd_sel)
          begin
            st_next.rsp.prdata = {24'h00_0000, ind_byte};
          end
        end
        default: st_next.rsp.pslverr = 1'b1;
      endcase
    end
    // register writes
    if (acc && apb_req.pwrite)
    begin
      case (apb_req.paddr)
        SEL_ADDR: st_next.sel = apb_req.pwdata[7:0];
        OFF_ADDR: st_next.off = apb_req.pwdata[7:0];
        DATA_ADDR:
        begin
          if (wr_sel)
          begin
            if (st_reg.off <= LAST_BYTE)
            begin
              st_next.hold[pidx][off_lo] = apb_req.pwdata[7:0];
            end
            else if (st_reg.off == BE_UPPER_OFF)
            begin
              st_next.be[pidx][13:8] = apb_req.pwdata[5:0];
            end
            else if (st_reg.off == BE_LOWER_OFF)
            begin
              st_next.be[pidx][7:0] = apb_req.pwdata[7:0];
            end
            else if (st_reg.off == CTL_OFF &&
                     st_reg.eng == S_IDLE)
            begin
              st_next.ctl[pidx] = apb_req.pwdata[4:0];
              st_next.op_port = pidx;
              st_next.op_idx = apb_req.pwdata[3:0];
              if (apb_req.pwdata[CTL_DIR_BIT])
              begin
                st_next.wr_done = 1'b0;
                st_next.eng = S_WRITE;
              end
              else
              begin
                st_next.rd_done = 1'b0;
                st_next.eng = S_READ;
              end
            end
          end
        end
        default: st_next.sel = st_reg.sel;
      endcase
    end
    // entry offsets advance for burst access; control offset stays
    if (acc && data_hit && port_ok && st_reg.off < LAST_BYTE)
    begin
      st_next.off = st_reg.off + 8'd1;
    end
    // transfer engine
    case (st_reg.eng)
      S_IDLE: st_next.eng = st_next.eng;
      S_READ:
      begin
        for (int k = 0; k < ENTRY_BYTES; k++)
        begin
          if (st_reg.be[st_reg.op_port][ENTRY_BYTES-1-k])
          begin
            st_next.fetch[st_reg.op_port][k] = mem_rd[8*k +: 8];
          end
        end
        st_next.rd_done = 1'b1;
        st_next.eng = S_IDLE;
      end
      S_WRITE:
      begin
        st_next.wr_done = 1'b1;
        st_next.eng = S_IDLE;
      end
      default: st_next.eng = S_IDLE;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.rd_done <= RESET_DONE;
      st_reg.wr_done <= RESET_DONE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_reset_flags: assert property (
    $fell(srst) |-> st_reg.rd_done && st_reg.wr_done &&
    st_reg.ctl == {PORTS{RESET_CTL}} && st_reg.eng == S_IDLE &&
    !st_reg.rsp.pready)
    else $error("done flags or control wrong after reset");

  a_table_guard: assert property (
    acc && apb_req.pwrite && data_hit && !wr_sel
    |=> st_reg.hold == $past(st_reg.hold) &&
        st_reg.be == $past(st_reg.be) &&
        st_reg.ctl == $past(st_reg.ctl))
    else $error("data write landed without write selection");

  a_enable_store: assert property (
    acc && apb_req.pwrite && data_hit && wr_sel &&
    st_reg.off == BE_UPPER_OFF
    |=> st_reg.be[$past(pidx)][13:8] == $past(apb_req.pwdata[5:0]))
    else $error("upper byte enable not stored");

  a_control_store: assert property (
    acc && apb_req.pwrite && data_hit && wr_sel &&
    st_reg.off == CTL_OFF && st_reg.eng == S_IDLE
    |=> st_reg.ctl[$past(pidx)] == $past(apb_req.pwdata[4:0]) &&
        st_reg.op_idx == $past(apb_req.pwdata[3:0]))
    else $error("transfer control not stored");

  a_offset_stay: assert property (
    acc && data_hit && st_reg.off >= LAST_BYTE
    |=> st_reg.off == $past(st_reg.off))
    else $error("offset moved past last entry byte");

  a_select_store: assert property (
    acc && apb_req.pwrite && apb_req.paddr == SEL_ADDR
    |=> st_reg.sel == $past(apb_req.pwdata[7:0]))
    else $error("select register not stored");

  a_offset_store: assert property (
    acc && apb_req.pwrite && apb_req.paddr == OFF_ADDR
    |=> st_reg.off == $past(apb_req.pwdata[7:0]))
    else $error("offset register not stored");

  a_hold_land: assert property (
    acc && apb_req.pwrite && data_hit && wr_sel &&
    st_reg.off <= LAST_BYTE
    |=> st_reg.hold[$past(pidx)][$past(off_lo)] ==
        $past(apb_req.pwdata[7:0]))
    else $error("entry byte missed holding buffer");

  a_burst_step: assert property (
    acc && data_hit && port_ok && st_reg.off < LAST_BYTE
    |=> st_reg.off == $past(st_reg.off) + 8'd1)
    else $error("offset did not advance");

  a_write_flag: assert property (
    acc && apb_req.pwrite && data_hit && wr_sel &&
    st_reg.off == CTL_OFF && st_reg.eng == S_IDLE &&
    apb_req.pwdata[CTL_DIR_BIT]
    |=> !st_reg.wr_done ##1 st_reg.wr_done)
    else $error("write-done flag timing wrong");

  a_read_flag: assert property (
    acc && apb_req.pwrite && data_hit && wr_sel &&
    st_reg.off == CTL_OFF && st_reg.eng == S_IDLE &&
    !apb_req.pwdata[CTL_DIR_BIT]
    |=> !st_reg.rd_done ##1 st_reg.rd_done)
    else $error("read-done flag timing wrong");

  a_fetch_full: assert property (
    st_reg.eng == S_READ && &st_reg.be[st_reg.op_port]
    |=> st_reg.fetch[$past(st_reg.op_port)] == $past(mem_rd))
    else $error("fetched entry differs from table");

  a_write_sel_read: assert property (
    apb_req.psel && apb_req.penable && !st_reg.rsp.pready &&
    data_hit && !rd_sel
    |=> st_reg.rsp.pready && st_reg.rsp.prdata == 32'h0000_0000)
    else $error("data read without read selection");

endmodule : rule_table_indirect_access

/* logic/rule_table_pkg.sv */
// Overview of operation
// - write-select codes pick port, 0x41 upward
// - read-select codes pick port, 0x51 upward
// - offset write selects the indirect byte
// - byte-enable word spans upper and lower bytes
// - enable bits map descending over entry bytes
// - control write, direction set, stores entry
// - control write, direction clear, fetches entry
// - read-done clear during fetch, set after
// - write-done clear during write, set after
// - entry bytes land in per-port holding buffer
// - burst accesses walk consecutive entry offsets
// - entry bytes kept opaque, any rule format
// - select bits 7:5 table, 3:0 port
// - done flags reset to one, control zero
package rule_table_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] SEL_IDX = 8'h6E;
  localparam logic [7:0] OFF_IDX = 8'h6F;
  localparam logic [7:0] DATA_IDX = 8'hA0;
  localparam logic [11:0] SEL_ADDR = {2'b00, SEL_IDX, 2'b00};
  localparam logic [11:0] OFF_ADDR = {2'b00, OFF_IDX, 2'b00};
  localparam logic [11:0] DATA_ADDR = {2'b00, DATA_IDX, 2'b00};
  // ****************************************
  // indirect layout
  // ****************************************
  localparam logic [2:0] TABLE_RULE = 3'b010;
  localparam int SEL_DIR_BIT = 4;
  localparam logic [3:0] PORT_FIRST = 4'h1;
  localparam logic [3:0] PORT_LAST = 4'h5;
  localparam int PORTS = 5;
  localparam int ENTRY_BYTES = 14;
  localparam int ENTRIES = 16;
  localparam logic [7:0] LAST_BYTE = 8'h0D;
  localparam logic [7:0] BE_UPPER_OFF = 8'h10;
  localparam logic [7:0] BE_LOWER_OFF = 8'h11;
  localparam logic [7:0] CTL_OFF = 8'h12;
  localparam int CTL_DIR_BIT = 4;
  localparam int CTL_RD_DONE_BIT = 5;
  localparam int CTL_WR_DONE_BIT = 6;
  localparam logic RESET_DONE = 1'b1;
  localparam logic [4:0] RESET_CTL = 5'h00;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_READ = 2'b01,
    S_WRITE = 2'b10
  } eng_type;
endpackage : rule_table_pkg

/* sim/rule_table_indirect_access_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module rule_table_indirect_access_tb_top
  import rule_table_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  apb_req_type apb_req = '0;
  apb_rsp_type apb_rsp;
  int err_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] ent_a [14];
  logic [7:0] ent_b [14];
  logic [3:0] p;
  logic [3:0] idx;

  always #2.5 clk = ~clk;

  rule_table_indirect_access rule_table_indirect_access_inst (
    .clk(clk),
    .srst(srst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp)
  );

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 50)
      err_count++;
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic ind_wr(input logic [7:0] s, input logic [7:0] o,
                        input logic [7:0] d);
    apb(1'b1, SEL_ADDR, s);
    apb(1'b1, OFF_ADDR, o);
    apb(1'b1, DATA_ADDR, d);
  endtask : ind_wr

  task automatic ind_rd(input logic [7:0] s, input logic [7:0] o);
    apb(1'b1, SEL_ADDR, s);
    apb(1'b1, OFF_ADDR, o);
    apb(1'b0, DATA_ADDR, 8'h00);
  endtask : ind_rd

  task automatic set_be(input logic [3:0] q, input logic [7:0] u,
                        input logic [7:0] l);
    ind_wr({4'h4, q}, BE_UPPER_OFF, u);
    ind_wr({4'h4, q}, BE_LOWER_OFF, l);
  endtask : set_be

  // burst load of the holding buffer from ent_b
  task automatic load(input logic [3:0] q);
    apb(1'b1, SEL_ADDR, {4'h4, q});
    apb(1'b1, OFF_ADDR, 8'h00);
    for (int k = 0; k < ENTRY_BYTES; k++)
      apb(1'b1, DATA_ADDR, ent_b[k]);
  endtask : load

  task automatic ctl(input logic [3:0] q, input logic [7:0] v);
    int n;
    n = 0;
    ind_wr({4'h4, q}, CTL_OFF, v);
    ind_rd({4'h5, q}, CTL_OFF);
    // poll until both done flags read back set
    while (rd[6:5] !== 2'b11 && n < 20)
    begin
      n++;
      apb(1'b0, DATA_ADDR, 8'h00);
    end
    `CHK("control", {3'b011, v[4:0]}, rd[7:0])
  endtask : ctl

  function automatic logic [7:0] merge(input logic [7:0] a,
    input logic [7:0] b, input logic [13:0] be, input int k);
    return be[13 - k] ? b : a;
  endfunction : merge

  // fetch with all bytes enabled, then burst read the entry
  task automatic fetch_chk(input logic [3:0] q, input logic [3:0] i,
                           input logic [13:0] be);
    set_be(q, 8'h3F, 8'hFF);
    ctl(q, {4'h0, i});
    apb(1'b1, SEL_ADDR, {4'h5, q});
    apb(1'b1, OFF_ADDR, 8'h00);
    for (int k = 0; k < ENTRY_BYTES; k++)
    begin
      apb(1'b0, DATA_ADDR, 8'h00);
      `CHK("entry byte", merge(ent_a[k], ent_b[k], be, k), rd[7:0])
    end
    // single byte reads, offset written before each read
    for (int k = 0; k < ENTRY_BYTES; k++)
    begin
      apb(1'b1, OFF_ADDR, 8'(k));
      apb(1'b0, DATA_ADDR, 8'h00);
      `CHK("single byte", merge(ent_a[k], ent_b[k], be, k), rd[7:0])
    end
  endtask : fetch_chk

  task automatic results();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    void'($urandom(97337));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int q = 1; q <= PORTS; q++)
    begin
      ind_rd({4'h5, 4'(q)}, CTL_OFF);
      `CHK("reset control", 8'h60, rd[7:0])
    end
    apb(1'b1, 12'h004, 8'h00);
    `CHK("unmapped error", 1'b1, er)
    for (int t = 0; t < 3; t++)
    begin
      p = (t == 0) ? PORT_LAST : 4'($urandom_range(1, 5));
      idx = (t == 0) ? 4'hF : 4'($urandom);
      set_be(p, 8'h3F, 8'hFF);
      ind_rd({4'h5, p}, BE_UPPER_OFF);
      `CHK("enable upper", 8'h3F, rd[7:0])
      // wrong table and read view must not touch the enables
      ind_wr({3'b001, 1'b0, p}, BE_UPPER_OFF, 8'h00);
      ind_wr({4'h5, p}, BE_UPPER_OFF, 8'h00);
      ind_rd({4'h5, p}, BE_UPPER_OFF);
      `CHK("enable guard", 8'h3F, rd[7:0])
      ind_rd({4'h4, p}, CTL_OFF);
      `CHK("write view read", 8'h00, rd[7:0])
      foreach (ent_a[k])
        ent_a[k] = 8'($urandom);
      ent_b = ent_a;
      load(p);
      ctl(p, {4'h1, idx});
      fetch_chk(p, idx, 14'h3FFF);
      foreach (ent_b[k])
        ent_b[k] = 8'($urandom);
      load(p);
      set_be(p, 8'h15, 8'h55);
      ctl(p, {4'h1, idx});
      fetch_chk(p, idx, 14'h1555);
    end
    results();
  end

  initial
  begin
    repeat (10000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : rule_table_indirect_access_tb_top
